// File: hw/rwj_params.svh
// Offsets, field positions, reset values and timing figures of the watchdog block.
`ifndef RWJ_PARAMS_SVH
`define RWJ_PARAMS_SVH
`define RWJ_OFS_WDJ_CTRL 8'h78
`define RWJ_OFS_STATUS2 8'h80
`define RWJ_BIT_RX_RELEASE_SEL 5
`define RWJ_BIT_RX_WDOG_OFF 4
`define RWJ_BIT_JAB_CUTOFF_SEL 2
`define RWJ_BIT_JAB_NO_HOLDOFF 1
`define RWJ_BIT_JAB_OFF 0
`define RWJ_CTRL_RESET 32'h00000000
`define RWJ_POS_TX_EARLY 31
`define RWJ_POS_RX_EARLY 30
`define RWJ_POS_XCVR 29
`define RWJ_POS_TX_DEFER 28
`define RWJ_POS_PAUSE 26
`define RWJ_POS_NORMAL_SUM 16
`define RWJ_POS_ABNORMAL_SUM 15
`define RWJ_FLAG_RESET 7'h44
`define RWJ_CLK_MHZ 40
`define RWJ_BITS_PER_BYTE 8
`define RWJ_RX_MAX_BYTES 2560
`define RWJ_RX_RELEASE_SHORT_BITS 24
`define RWJ_RX_RELEASE_LONG_BITS 48
`define RWJ_JAB_MAX_BYTES 2560
`define RWJ_JAB_CUT_100_US 2600
`define RWJ_JAB_CUT_10_US 26000
`define RWJ_JAB_HOLD_100_US 42000
`define RWJ_JAB_HOLD_10_US 420000
`endif

// File: hw/rwj_pkg.sv
// Types shared by the watchdog and jabber block.
package rwj_pkg;
   typedef enum logic [1:0] {RW_IDLE, RW_RECV, RW_TRIP, RW_RELEASE} rwj_rx_state_t;
   typedef enum logic [1:0] {JB_IDLE, JB_COUNT, JB_HOLD, JB_DRAIN} rwj_jab_state_t;
endpackage

// File: hw/rwj_latch_flag.sv
// One high-latching status flag with write-one-to-clear.
module rwj_latch_flag #(
   parameter bit RST_VAL = 1'b0
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic setEv,
   input wire logic clrEv,
   output logic flag
);
   logic next_flag;

   // A set in the clear cycle wins, so no event is lost.
   always_comb begin
      next_flag = flag;
      if (clrEv) begin
         next_flag = 1'b0;
      end
      if (setEv) begin
         next_flag = 1'b1;
      end
   end

   // Flag register.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag <= RST_VAL;
      end else begin
         flag <= next_flag;
      end
   end
endmodule

// File: hw/rwj_tick_counter.sv
// Up counter with synchronous clear and count enable.
module rwj_tick_counter #(
   parameter int W = 32
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic inc,
   output logic [W-1:0] count
);
   logic [W-1:0] next_count;

   // Clear has priority over counting.
   always_comb begin
      next_count = count;
      if (clear) begin
         next_count = '0;
      end else if (inc) begin
         next_count = count + {{(W-1){1'b0}}, 1'b1};
      end
   end

   // Count register.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end
endmodule

// File: hw/rwj_top.sv
// Watchdog and jabber control register, secondary status register and their timers.
//
// What this block does
// - Release bit picks 24 or 48 bit-times from carrier loss to watchdog release.
// - Receive watchdog trips beyond 2560 bytes unless its off bit is set.
// - Cut-off select clear: stop transmission after 2.6 ms or 26 ms.
// - Cut-off select set: stop transmission after 2560 byte-times at any speed.
// - No-holdoff clear: keep transmit disabled 42 ms or 420 ms after jabber.
// - No-holdoff set: after jabber expiry, transmit stays cut off until the transmission ends, then is enabled again.
// - Jabber off bit disables jabber cut-off; all control bits reset to zero.
// - Transmit early flag, bit 31, set when enabled and packet moved; write one clears.
// - Receive early flag, bit 30, set when enabled and first descriptor filled.
// - Transceiver flag, bit 29, latches OR of transceiver bits 6..0; resets to one.
// - Transmit deferred flag at bit 28 latches high and resets to zero.
// - Pause flag, bit 26, latches when a pause frame arrives with pause enabled.
// - Bus error kind, bits 25..23, read-only, valid only with fatal bus error.
// - Transmit state code shows in bits 22..20, read-only, no interrupt.
// - Receive state code shows in bits 19..17, read-only, no interrupt.
// - Normal summary, bit 16, latches on any normal source; resets to zero.
// - Abnormal summary, bit 15, latches on any abnormal source; resets to one.
// - Bits 14..0 mirror the primary status register for read and clear.
//
// The plain strobed port was chosen for this implementation.
`include "rwj_params.svh"
module rwj_top
   import rwj_pkg::*;
#(
   parameter int JAB_CUT_100_CYC = `RWJ_JAB_CUT_100_US * `RWJ_CLK_MHZ,
   parameter int JAB_CUT_10_CYC = `RWJ_JAB_CUT_10_US * `RWJ_CLK_MHZ,
   parameter int JAB_HOLD_100_CYC = `RWJ_JAB_HOLD_100_US * `RWJ_CLK_MHZ,
   parameter int JAB_HOLD_10_CYC = `RWJ_JAB_HOLD_10_US * `RWJ_CLK_MHZ
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   input wire logic bitTick,
   input wire logic speed100,
   input wire logic rxCarrier,
   input wire logic txActive,
   input wire logic txEarlyEvent,
   input wire logic tx_early_irq_en,
   input wire logic rxEarlyEvent,
   input wire logic rx_early_irq_en,
   input wire logic [6:0] transceiver_irq_reg,
   input wire logic txDeferredEvent,
   input wire logic pauseFrameEvent,
   input wire logic pauseEnable,
   input wire logic fatal_bus_error_flag,
   input wire logic [2:0] bus_error_kind,
   input wire logic [2:0] transmit_state_field,
   input wire logic [2:0] receive_state_field,
   input wire logic [14:0] primary_status_reg,
   output logic [14:0] primaryClear,
   output logic rxWdogExpired,
   output logic txCutoff
);

   ////////////////////////////////////////////////////////////////////////////
   // Constants derived from the header figures.
   localparam logic [31:0] RX_MAX_BITS = 32'(`RWJ_RX_MAX_BYTES * `RWJ_BITS_PER_BYTE);
   localparam logic [31:0] JAB_MAX_BITS = 32'(`RWJ_JAB_MAX_BYTES * `RWJ_BITS_PER_BYTE);
   localparam logic [31:0] REL_SHORT = 32'(`RWJ_RX_RELEASE_SHORT_BITS);
   localparam logic [31:0] REL_LONG = 32'(`RWJ_RX_RELEASE_LONG_BITS);
   localparam int NFLAG = 7;
   localparam logic [31:0] CTRL_RST = `RWJ_CTRL_RESET;
   localparam logic [NFLAG-1:0] FLAG_RST = `RWJ_FLAG_RESET;

   // Bit position of each latching flag in the secondary status register.
   function automatic int flagPos(input int idx);
      int pos;
      pos = 0;
      unique case (idx)
         0: pos = `RWJ_POS_TX_EARLY;
         1: pos = `RWJ_POS_RX_EARLY;
         2: pos = `RWJ_POS_XCVR;
         3: pos = `RWJ_POS_TX_DEFER;
         4: pos = `RWJ_POS_PAUSE;
         5: pos = `RWJ_POS_NORMAL_SUM;
         default: pos = `RWJ_POS_ABNORMAL_SUM;
      endcase
      return pos;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register bus decode.
   logic ctrlWr;
   logic statusWr;
   // Address decode for the two mapped words.
   assign ctrlWr = regWr && (regAddr == `RWJ_OFS_WDJ_CTRL);
   assign statusWr = regWr && (regAddr == `RWJ_OFS_STATUS2);

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog and jabber control register.
   logic rx_wdog_release_sel;
   logic rx_wdog_off;
   logic jabber_cutoff_sel;
   logic jabber_no_holdoff;
   logic jabber_off;
   logic next_rx_wdog_release_sel;
   logic next_rx_wdog_off;
   logic next_jabber_cutoff_sel;
   logic next_jabber_no_holdoff;
   logic next_jabber_off;

   // Only the five defined bits are stored; the rest are dropped.
   always_comb begin
      next_rx_wdog_release_sel = rx_wdog_release_sel;
      next_rx_wdog_off = rx_wdog_off;
      next_jabber_cutoff_sel = jabber_cutoff_sel;
      next_jabber_no_holdoff = jabber_no_holdoff;
      next_jabber_off = jabber_off;
      if (ctrlWr) begin
         next_rx_wdog_release_sel = regWrData[`RWJ_BIT_RX_RELEASE_SEL];
         next_rx_wdog_off = regWrData[`RWJ_BIT_RX_WDOG_OFF];
         next_jabber_cutoff_sel = regWrData[`RWJ_BIT_JAB_CUTOFF_SEL];
         next_jabber_no_holdoff = regWrData[`RWJ_BIT_JAB_NO_HOLDOFF];
         next_jabber_off = regWrData[`RWJ_BIT_JAB_OFF];
      end
   end

   // Control bits clear on reset.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_wdog_release_sel <= CTRL_RST[`RWJ_BIT_RX_RELEASE_SEL];
         rx_wdog_off <= CTRL_RST[`RWJ_BIT_RX_WDOG_OFF];
         jabber_cutoff_sel <= CTRL_RST[`RWJ_BIT_JAB_CUTOFF_SEL];
         jabber_no_holdoff <= CTRL_RST[`RWJ_BIT_JAB_NO_HOLDOFF];
         jabber_off <= CTRL_RST[`RWJ_BIT_JAB_OFF];
      end else begin
         rx_wdog_release_sel <= next_rx_wdog_release_sel;
         rx_wdog_off <= next_rx_wdog_off;
         jabber_cutoff_sel <= next_jabber_cutoff_sel;
         jabber_no_holdoff <= next_jabber_no_holdoff;
         jabber_off <= next_jabber_off;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Latching status flags.
   logic [NFLAG-1:0] flagSet;
   logic [NFLAG-1:0] flag;

   // Event sources; early flags only latch while their enables are set.
   always_comb begin
      flagSet[0] = txEarlyEvent && tx_early_irq_en;
      flagSet[1] = rxEarlyEvent && rx_early_irq_en;
      flagSet[2] = |transceiver_irq_reg;
      flagSet[3] = txDeferredEvent;
      flagSet[4] = pauseFrameEvent && pauseEnable;
      flagSet[5] = flagSet[0] || flagSet[1];
      flagSet[6] = flagSet[2] || flagSet[3] || flagSet[4];
   end

   // One flag cell per bit; a written one clears, a same-cycle set wins.
   generate
      for (genvar i = 0; i < NFLAG; i++) begin : g_flag
         rwj_latch_flag #(
            .RST_VAL(FLAG_RST[i])
         ) u_flag (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .setEv(flagSet[i]),
            .clrEv(statusWr && regWrData[flagPos(i)]),
            .flag(flag[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Primary status mirror clear strobes.
   logic [14:0] next_primaryClear;

   // Ones written to the low bits are passed on as a one-cycle clear.
   always_comb begin
      next_primaryClear = statusWr ? regWrData[14:0] : 15'h0000;
   end

   // Clear strobe register.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         primaryClear <= 15'h0000;
      end else begin
         primaryClear <= next_primaryClear;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive watchdog.
   rwj_rx_state_t rxState;
   rwj_rx_state_t next_rxState;
   logic [31:0] rxCount;
   logic rxClear;
   logic rxInc;
   logic next_rxWdogExpired;

   // Counts bit-times of the frame, then bit-times of the release delay.
   always_comb begin
      next_rxState = rxState;
      rxInc = bitTick;
      unique case (rxState)
         RW_IDLE: begin
            if (rxCarrier && !rx_wdog_off) begin
               next_rxState = RW_RECV;
            end
         end
         RW_RECV: begin
            if (rx_wdog_off || !rxCarrier) begin
               next_rxState = RW_IDLE;
            end else if (rxCount > RX_MAX_BITS) begin
               next_rxState = RW_TRIP;
            end
         end
         RW_TRIP: begin
            if (!rxCarrier) begin
               next_rxState = RW_RELEASE;
            end
         end
         RW_RELEASE: begin
            if (rxCarrier) begin
               next_rxState = RW_TRIP;
            end else if (rxCount >= (rx_wdog_release_sel ? REL_LONG : REL_SHORT)) begin
               next_rxState = RW_IDLE;
            end
         end
      endcase
      rxClear = (next_rxState != rxState) || (rxState == RW_IDLE);
      next_rxWdogExpired = (next_rxState == RW_TRIP) || (next_rxState == RW_RELEASE);
   end

   // Receive watchdog state register.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rxState <= RW_IDLE;
         rxWdogExpired <= 1'b0;
      end else begin
         rxState <= next_rxState;
         rxWdogExpired <= next_rxWdogExpired;
      end
   end

   // Bit-time counter of the receive watchdog.
   rwj_tick_counter #(
      .W(32)
   ) u_rx_count (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clear(rxClear),
      .inc(rxInc),
      .count(rxCount)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Transmit jabber timer.
   rwj_jab_state_t jabState;
   rwj_jab_state_t next_jabState;
   logic [31:0] jabCount;
   logic [31:0] cutLimit;
   logic [31:0] holdLimit;
   logic jabClear;
   logic jabInc;
   logic next_txCutoff;

   // Limits follow the cut-off select and the current link speed.
   always_comb begin
      if (jabber_cutoff_sel) begin
         cutLimit = JAB_MAX_BITS;
      end else begin
         cutLimit = speed100 ? 32'(JAB_CUT_100_CYC) : 32'(JAB_CUT_10_CYC);
      end
      holdLimit = speed100 ? 32'(JAB_HOLD_100_CYC) : 32'(JAB_HOLD_10_CYC);
   end

   // Times a transmission, cuts it off, then holds transmit off if asked.
   always_comb begin
      next_jabState = jabState;
      jabInc = 1'b1;
      unique case (jabState)
         JB_IDLE: begin
            if (txActive && !jabber_off) begin
               next_jabState = JB_COUNT;
            end
         end
         JB_COUNT: begin
            jabInc = jabber_cutoff_sel ? bitTick : 1'b1;
            if (jabber_off || !txActive) begin
               next_jabState = JB_IDLE;
            end else if (jabCount >= cutLimit) begin
               next_jabState = jabber_no_holdoff ? JB_DRAIN : JB_HOLD;
            end
         end
         JB_HOLD: begin
            if (jabCount >= holdLimit) begin
               next_jabState = JB_IDLE;
            end
         end
         JB_DRAIN: begin
            if (!txActive) begin
               next_jabState = JB_IDLE;
            end
         end
      endcase
      jabClear = (next_jabState != jabState) || (jabState == JB_IDLE);
      next_txCutoff = (next_jabState == JB_HOLD) || (next_jabState == JB_DRAIN);
   end

   // Jabber state register.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         jabState <= JB_IDLE;
         txCutoff <= 1'b0;
      end else begin
         jabState <= next_jabState;
         txCutoff <= next_txCutoff;
      end
   end

   // Cycle or bit-time counter of the jabber timer.
   rwj_tick_counter #(
      .W(32)
   ) u_jab_count (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clear(jabClear),
      .inc(jabInc),
      .count(jabCount)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data.
   logic [31:0] next_regRdData;
   logic [31:0] statusWord;

   // Assemble both words; unmapped addresses and reserved bits read zero.
   always_comb begin
      statusWord = 32'h00000000;
      for (int i = 0; i < NFLAG; i++) begin
         statusWord[flagPos(i)] = flag[i];
      end
      statusWord[25:23] = fatal_bus_error_flag ? bus_error_kind : 3'h0;
      statusWord[22:20] = transmit_state_field;
      statusWord[19:17] = receive_state_field;
      statusWord[14:0] = primary_status_reg;
      next_regRdData = 32'h00000000;
      if (regRd) begin
         if (regAddr == `RWJ_OFS_WDJ_CTRL) begin
            next_regRdData[`RWJ_BIT_RX_RELEASE_SEL] = rx_wdog_release_sel;
            next_regRdData[`RWJ_BIT_RX_WDOG_OFF] = rx_wdog_off;
            next_regRdData[`RWJ_BIT_JAB_CUTOFF_SEL] = jabber_cutoff_sel;
            next_regRdData[`RWJ_BIT_JAB_NO_HOLDOFF] = jabber_no_holdoff;
            next_regRdData[`RWJ_BIT_JAB_OFF] = jabber_off;
         end else if (regAddr == `RWJ_OFS_STATUS2) begin
            next_regRdData = statusWord;
         end
      end
   end

   // Read data stand for one cycle after the read strobe.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= 32'h00000000;
      end else begin
         regRdData <= next_regRdData;
      end
   end
endmodule

// File: verification/rwj_top_assertions.sv
// Concurrent checks on the ports of the watchdog, jabber and secondary status block.
module rwj_top_assertions (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdData,
   input wire logic txActive,
   input wire logic [6:0] transceiver_irq_reg,
   input wire logic pauseFrameEvent,
   input wire logic pauseEnable,
   input wire logic [2:0] transmit_state_field,
   input wire logic [2:0] receive_state_field,
   input wire logic [14:0] primary_status_reg,
   input wire logic [14:0] primaryClear,
   input wire logic rxWdogExpired,
   input wire logic txCutoff
);
   logic jabOff;
   logic rxOff;
   logic noHold;
   logic [14:0] wrLow;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // Shadow copies of the watchdog off, no-holdoff and jabber off control bits, taken from writes seen on the bus.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         {rxOff, noHold, jabOff} <= 3'h0;
      end else if (regWr && regAddr == 8'h78) begin
         {rxOff, noHold, jabOff} <= {regWrData[4], regWrData[1:0]};
      end
   end
   assign wrLow = regWrData[14:0];

   sequence rdCtrl;
      regRd && regAddr == 8'h78;
   endsequence
   sequence rdStat;
      regRd && regAddr == 8'h80;
   endsequence
   sequence pauseSeen;
      pauseFrameEvent && pauseEnable;
   endsequence

   ctrl_reserved_a: assert property (rdCtrl |=> regRdData[31:6] == 26'h0 && !regRdData[3])
      else $error("control reserved bits read nonzero");
   status_reserved_a: assert property (rdStat |=> !regRdData[27])
      else $error("status bit 27 reads nonzero");
   mirror_read_a: assert property (rdStat |=> regRdData[14:0] == $past(primary_status_reg))
      else $error("low status bits do not mirror primary status");
   state_fields_a: assert property (rdStat |=> regRdData[22:17] ==
         {$past(transmit_state_field), $past(receive_state_field)})
      else $error("state fields do not match inputs");
   clear_pulse_a: assert property (regWr && regAddr == 8'h80 |=> primaryClear == $past(wrLow))
      else $error("primary clear differs from written bits");
   clear_quiet_a: assert property (!(regWr && regAddr == 8'h80) |=> primaryClear == 15'h0)
      else $error("primary clear without a status write");
   pause_latch_a: assert property (pauseSeen ##1 !(regWr && regWrData[26]) ##1 rdStat
         |=> regRdData[26])
      else $error("pause flag not latched");
   xcvr_latch_a: assert property ((|transceiver_irq_reg) ##1 !regWr ##1 rdStat
         |=> regRdData[29] && regRdData[15])
      else $error("transceiver flag or abnormal summary not latched");
   jabber_off_a: assert property (jabOff && !txCutoff |=> !txCutoff)
      else $error("cut-off while jabber is off");
   rx_wdog_off_a: assert property (rxOff && !rxWdogExpired |=> !rxWdogExpired)
      else $error("receive watchdog tripped while off");
   no_holdoff_a: assert property (noHold && txCutoff && $fell(txActive) |-> ##[0:3] !txCutoff)
      else $error("cut-off held without hold-off");
endmodule

// File: verification/rwj_top_tb_top.sv
// Self-checking bench for the watchdog, jabber and secondary status block.
module rwj_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0, bitTick = 1'b1;
   logic speed100 = 1'b1, rxCarrier = 1'b0, txActive = 1'b0, txEarlyEvent = 1'b0;
   logic rxEarlyEvent = 1'b0, txDeferredEvent = 1'b0, pauseFrameEvent = 1'b0;
   logic tx_early_irq_en = 1'b1, rx_early_irq_en = 1'b1, pauseEnable = 1'b1;
   logic fatal_bus_error_flag = 1'b0, rxWdogExpired, txCutoff;
   logic [7:0] regAddr = 8'h0;
   logic [31:0] regWrData = 32'h0, regRdData, flagExp, v;
   logic [6:0] transceiver_irq_reg = 7'h0;
   logic [2:0] bus_error_kind = 3'h0, transmit_state_field = 3'h0, receive_state_field = 3'h0;
   logic [14:0] primary_status_reg = 15'h0, primaryClear;
   int badCount = 0, numChecks = 0, pos[5] = '{31, 30, 29, 28, 26};

   rwj_top #(.JAB_CUT_100_CYC(50), .JAB_CUT_10_CYC(80), .JAB_HOLD_100_CYC(100),
      .JAB_HOLD_10_CYC(150)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .bitTick(bitTick), .speed100(speed100), .rxCarrier(rxCarrier), .txActive(txActive),
      .txEarlyEvent(txEarlyEvent), .tx_early_irq_en(tx_early_irq_en),
      .rxEarlyEvent(rxEarlyEvent), .rx_early_irq_en(rx_early_irq_en),
      .transceiver_irq_reg(transceiver_irq_reg), .txDeferredEvent(txDeferredEvent),
      .pauseFrameEvent(pauseFrameEvent), .pauseEnable(pauseEnable),
      .fatal_bus_error_flag(fatal_bus_error_flag), .bus_error_kind(bus_error_kind),
      .transmit_state_field(transmit_state_field), .receive_state_field(receive_state_field),
      .primary_status_reg(primary_status_reg), .primaryClear(primaryClear),
      .rxWdogExpired(rxWdogExpired), .txCutoff(txCutoff));

   // Clock at 40 MHz.
   always #12.5 ref_clk = ~ref_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkRange(input int c, input int lo, input int hi);
      chk((c >= lo && c <= hi) ? lo : c, lo);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   task automatic chkRd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   // Reads the status word and compares it with the model built from flags and inputs.
   task automatic chkStat();
      logic [31:0] d;
      logic [2:0] k;
      rd(8'h80, d);
      k = fatal_bus_error_flag ? bus_error_kind : 3'h0;
      chk(d, flagExp | {6'h0, k, transmit_state_field, receive_state_field, 17'h0}
         | {17'h0, primary_status_reg});
   endtask
   // One-cycle event pulse, optionally alongside a write that clears every flag.
   task automatic pulse(input int i, input bit clr);
      @(posedge ref_clk);
      case (i)
         0: txEarlyEvent <= 1'b1;
         1: rxEarlyEvent <= 1'b1;
         2: transceiver_irq_reg <= 7'h1 << $urandom_range(0, 6);
         3: txDeferredEvent <= 1'b1;
         default: pauseFrameEvent <= 1'b1;
      endcase
      regWr <= clr;
      regAddr <= 8'h80;
      regWrData <= 32'hffff8000;
      @(posedge ref_clk);
      {txEarlyEvent, rxEarlyEvent, txDeferredEvent, pauseFrameEvent, regWr} <= 5'h0;
      transceiver_irq_reg <= 7'h0;
   endtask
   task automatic waitFor(input bit sel, input bit lvl, input int lim, output int c);
      c = 0;
      while (((sel ? txCutoff : rxWdogExpired) !== lvl) && c < lim) begin
         @(posedge ref_clk);
         c++;
      end
   endtask
   // Carrier held past the length limit, then dropped to time the release.
   task automatic rxRun(input bit rel, input bit off);
      int c;
      wr(8'h78, {26'h0, rel, off, 4'h0});
      @(posedge ref_clk);
      rxCarrier <= 1'b1;
      waitFor(1'b0, 1'b1, 21000, c);
      chkRange(c, off ? 21000 : 20480, off ? 21000 : 20486);
      @(posedge ref_clk);
      rxCarrier <= 1'b0;
      waitFor(1'b0, 1'b0, 300, c);
      chkRange(c, off ? 0 : (rel ? 46 : 22), off ? 0 : (rel ? 52 : 28));
   endtask
   // Transmission held until cut-off, then dropped to time the hold-off.
   task automatic jabRun(input logic [2:0] ctl, input bit sp, input int lo, input int hold);
      int c;
      wr(8'h78, {29'h0, ctl});
      @(posedge ref_clk);
      speed100 <= sp;
      txActive <= 1'b1;
      waitFor(1'b1, 1'b1, lo > 20000 ? 21000 : 300, c);
      chkRange(c, lo, lo + 4);
      @(posedge ref_clk);
      txActive <= 1'b0;
      waitFor(1'b1, 1'b0, 300, c);
      chkRange(c, hold - 2, hold + 3);
   endtask
   task automatic testDone();
      $display("checks=%0d mismatches=%0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence: reset, registers, flags, watchdog and jabber timing.
   initial begin
      v = $urandom(32'h355bb46c);
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      flagExp = 32'h20008000;
      chkRd(8'h78, 32'h0);
      chkStat();
      repeat (4) begin
         v = $urandom;
         wr(8'h78, v);
         chkRd(8'h78, v & 32'h37);
      end
      wr(8'h84, 32'hffffffff);
      chkRd(8'h84, 32'h0);
      chkRd(8'h78, v & 32'h37);
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         transmit_state_field <= 3'(i);
         receive_state_field <= 3'(7 - i);
         bus_error_kind <= 3'(i);
         fatal_bus_error_flag <= i[0];
         primary_status_reg <= 15'($urandom);
         chkStat();
         v = $urandom;
         wr(8'h80, v & 32'h00007fff);
         #1 chk({17'h0, primaryClear}, {17'h0, v[14:0]});
      end
      for (int i = 0; i < 5; i++) begin
         pulse(i, 1'b0);
         flagExp |= (32'h1 << pos[i]) | (i < 2 ? 32'h10000 : 32'h8000);
         chkStat();
         wr(8'h80, 32'h0);
         chkStat();
         wr(8'h80, 32'hffff8000);
         flagExp = 32'h0;
         chkStat();
      end
      pulse(4, 1'b1);
      flagExp = 32'h04008000;
      chkStat();
      wr(8'h80, 32'hffff8000);
      tx_early_irq_en <= 1'b0;
      pauseEnable <= 1'b0;
      rx_early_irq_en <= 1'b0;
      pulse(0, 1'b0);
      pulse(1, 1'b0);
      pulse(4, 1'b0);
      flagExp = 32'h0;
      chkStat();
      rxRun(1'b0, 1'b0);
      rxRun(1'b1, 1'b0);
      rxRun(1'b0, 1'b1);
      jabRun(3'b000, 1'b1, 50, 100);
      jabRun(3'b000, 1'b0, 80, 150);
      jabRun(3'b010, 1'b1, 50, 0);
      jabRun(3'b110, 1'b0, 20480, 0);
      jabRun(3'b001, 1'b1, 300, 0);
      testDone();
   end

   // Watchdog: a hang counts a mismatch and ends the run.
   initial begin
      #(95000 * 25);
      badCount++;
      testDone();
   end
endmodule

bind rwj_top rwj_top_assertions chk (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .txActive(txActive), .transceiver_irq_reg(transceiver_irq_reg),
   .pauseFrameEvent(pauseFrameEvent), .pauseEnable(pauseEnable),
   .transmit_state_field(transmit_state_field), .receive_state_field(receive_state_field),
   .primary_status_reg(primary_status_reg), .primaryClear(primaryClear),
   .rxWdogExpired(rxWdogExpired), .txCutoff(txCutoff));
